// File: include/lcc_defs.vh
`ifndef LCC_DEFS_VH
`define LCC_DEFS_VH

// register addresses
`define LCC_ADDR_PRIMARY 8'h08
`define LCC_ADDR_STATUS 8'h09
`define LCC_ADDR_MODE 8'h0a
`define LCC_ADDR_CONTROL 8'h0b

// field positions
`define LCC_PRI_CODE_HI 7
`define LCC_PRI_CODE_LO 4
`define LCC_STAT_SUPPLY 0
`define LCC_STAT_CHARGING 1
`define LCC_STAT_THERMAL 2
`define LCC_STAT_TIMEOUT 3
`define LCC_STAT_BATTERY 4
`define LCC_STAT_TMO_HI 7
`define LCC_STAT_TMO_LO 6
`define LCC_MODE_REGULATOR 7
`define LCC_MODE_ALT_HI 6
`define LCC_MODE_ALT_LO 4
`define LCC_CTL_SUSPEND 0
`define LCC_CTL_HEALTHY 1
`define LCC_CTL_SELECT 2
`define LCC_CTL_EXACT 3

// reset values of writable fields
`define LCC_RST_PRIMARY 4'h0
`define LCC_RST_TIMEOUT 2'h0
`define LCC_RST_ALTERNATE 3'h0
`define LCC_RST_REGULATOR 1'h0
`define LCC_RST_SELECT 1'h0
`define LCC_RST_EXACT 1'h0

// timeout select codes
`define LCC_TMO_60 2'h0
`define LCC_TMO_90 2'h1
`define LCC_TMO_120 2'h2
`define LCC_TMO_OFF 2'h3

// current mapping figures in mA
`define LCC_MA_LOW 10'h05a
`define LCC_MA_HIGH 10'h1c2
`define LCC_MA_BASE_PRI 10'h0fa
`define LCC_MA_STEP_PRI 10'h032
`define LCC_MA_BASE_ALT 10'h12c
`define LCC_MA_STEP_ALT 10'h064

// timing: minutes and clock rate
`define LCC_CLK_HZ 100000000
`define LCC_SEC_PER_MIN 60
// clock cycles in one minute at 100 MHz; needs 33 bits
`define LCC_MIN_CYCLES 33'd6000000000

`endif

// File: rtl/lcc_current_map.v
`timescale 1ns/1ns
`default_nettype none
`include "lcc_defs.vh"

module lcc_current_map (
  // selected codes
  input wire [3:0] primary_current_code_i,
  input wire [2:0] alternate_current_code_i,
  input wire use_alternate_i,
  input wire current_level_i,
  // charge current in mA
  output reg [9:0] charge_ma_o
);

  // pick primary or alternate code and scale to mA
  always @* begin
    if (use_alternate_i) begin
      charge_ma_o = `LCC_MA_BASE_ALT +
        `LCC_MA_STEP_ALT * {7'h00, alternate_current_code_i}; // R11
    end else if (primary_current_code_i == 4'h0) begin
      charge_ma_o = current_level_i ? `LCC_MA_HIGH : `LCC_MA_LOW; // R10
    end else begin
      charge_ma_o = `LCC_MA_BASE_PRI +
        `LCC_MA_STEP_PRI * {6'h00, primary_current_code_i}; // R10
    end
  end

endmodule // lcc_current_map
`default_nettype wire

// File: rtl/lcc_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "lcc_defs.vh"

// Contract
// [R1] four 8-bit registers at 08h..0Bh
// [R2] read-only bits ignore writes
// [R3] host writes write-exact bit with default
// [R4] 09h bit0 input supply good
// [R5] 09h bit2 thermal fault flag
// [R6] 09h bit4 battery removed flag
// [R7] 09h bits7:6 timeout select 60/90/120/off
// [R8] 0Ah bit7 linear regulator mode enable
// [R9] 0Bh bit2 current source select
// [R10] primary code maps to 90/450, 300..1000
// [R11] alternate code maps 300..1000 step 100
// [R12] charging flag and indicator in charge states
// [R13] auto start unless floating, suspended, fault; code also requires input good
// [R14] healthy: input above battery, uvlo, no fault
// [R15] alternate when pin high or select set
// [R16] 09h bit3 timeout fault after expiry
module lcc_regs #(
  parameter MIN_CYCLES = `LCC_MIN_CYCLES
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // register port from serial interface logic
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  output reg [7:0] reg_rdata_o,
  // analog status pins
  input wire input_above_battery_i,
  input wire input_above_uvlo_i,
  input wire thermal_fault_i,
  input wire battery_removed_i,
  input wire current_level_pin_i,
  input wire current_level_float_i,
  input wire [1:0] charger_state_i,
  // charger controls
  output reg charge_start_o,
  output reg linear_regulator_mode_o,
  output reg [9:0] charge_ma_o,
  output reg status_indicator_out_o,
  output wire status_indicator_oe_o
);

  // charger states reported by analog state machine
  localparam ST_IDLE = 2'h0;
  localparam ST_PRECOND = 2'h1;
  localparam ST_FAST = 2'h2;
  localparam ST_TOPOFF = 2'h3;

  reg [3:0] primary_current_code;
  reg [1:0] safety_timeout_select;
  reg [2:0] alternate_current_code;
  reg linear_regulator_mode;
  reg current_source_select;
  reg charge_suspend;
  reg write_exact;
  reg timer_expired_flag;
  reg [6:0] minute_count;
  reg [7:0] sync_a;
  reg [7:0] sync_b;
  reg [6:0] limit;
  reg [9:0] next_charge_ma;
  wire supply_s;
  wire above_bat_s;
  wire thermal_s;
  wire battery_s;
  wire level_s;
  wire float_s;
  wire [1:0] state_s;
  wire charging;
  wire fault;
  wire healthy;
  wire input_good;
  wire minute_tick;
  reg [32:0] tick_count;

  // two-stage sync of pin inputs
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end else begin
      sync_a <= {input_above_uvlo_i, input_above_battery_i, thermal_fault_i,
        battery_removed_i, current_level_pin_i, current_level_float_i,
        charger_state_i};
      sync_b <= sync_a;
    end
  end

  assign supply_s = sync_b[7];
  assign above_bat_s = sync_b[6];
  assign thermal_s = sync_b[5];
  assign battery_s = sync_b[4];
  assign level_s = sync_b[3];
  assign float_s = sync_b[2];
  assign state_s = sync_b[1:0];

  assign charging = (state_s == ST_PRECOND) || (state_s == ST_FAST) ||
    (state_s == ST_TOPOFF); // R12
  assign fault = thermal_s | battery_s | timer_expired_flag;
  // input good: above battery and above undervoltage threshold
  assign input_good = above_bat_s & supply_s; // R4
  assign healthy = above_bat_s & supply_s & ~fault; // R14

  // writable fields; read-only bits have no write path
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      primary_current_code <= `LCC_RST_PRIMARY;
      safety_timeout_select <= `LCC_RST_TIMEOUT;
      alternate_current_code <= `LCC_RST_ALTERNATE;
      linear_regulator_mode <= `LCC_RST_REGULATOR;
      current_source_select <= `LCC_RST_SELECT;
      charge_suspend <= 1'b0;
      write_exact <= `LCC_RST_EXACT;
    end else if (reg_wr_i) begin
      case (reg_addr_i) // R1 R2
        `LCC_ADDR_PRIMARY: begin
          primary_current_code <=
            reg_wdata_i[`LCC_PRI_CODE_HI:`LCC_PRI_CODE_LO]; // R10
        end
        `LCC_ADDR_STATUS: begin
          safety_timeout_select <=
            reg_wdata_i[`LCC_STAT_TMO_HI:`LCC_STAT_TMO_LO]; // R7
        end
        `LCC_ADDR_MODE: begin
          linear_regulator_mode <= reg_wdata_i[`LCC_MODE_REGULATOR]; // R8
          alternate_current_code <=
            reg_wdata_i[`LCC_MODE_ALT_HI:`LCC_MODE_ALT_LO]; // R11
        end
        `LCC_ADDR_CONTROL: begin
          charge_suspend <= reg_wdata_i[`LCC_CTL_SUSPEND];
          current_source_select <= reg_wdata_i[`LCC_CTL_SELECT]; // R9
          write_exact <= reg_wdata_i[`LCC_CTL_EXACT]; // R3
        end
        default: begin
        end
      endcase
    end
  end

  // one-minute enable pulse from the divider
  assign minute_tick = (tick_count >= MIN_CYCLES - 33'd1);

  // minute limit from timeout select
  always @* begin
    case (safety_timeout_select)
      `LCC_TMO_60: limit = 7'd60;
      `LCC_TMO_90: limit = 7'd90;
      `LCC_TMO_120: limit = 7'd120;
      default: limit = 7'd0;
    endcase
  end

  // safety timer: counts minutes while charging
  always @(posedge ref_clk_i) begin
    if (rst_i || !charging) begin
      tick_count <= 33'h0;
      minute_count <= 7'h00;
    end else if (minute_tick) begin
      tick_count <= 33'h0;
      minute_count <= minute_count + 7'h01;
    end else begin
      tick_count <= tick_count + 33'h1;
    end
  end

  // timeout flag; set wins; otherwise stays set until supply is lost or suspend
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      timer_expired_flag <= 1'b0;
    end else if (charging && safety_timeout_select != `LCC_TMO_OFF &&
      minute_count >= limit) begin
      timer_expired_flag <= 1'b1; // R16
    end else if (!supply_s || charge_suspend) begin
      timer_expired_flag <= 1'b0;
    end
  end

  // read mux
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        `LCC_ADDR_PRIMARY: reg_rdata_o <= {primary_current_code, 4'h0};
        `LCC_ADDR_STATUS: reg_rdata_o <= {safety_timeout_select, 1'b0,
          battery_s, timer_expired_flag, thermal_s, charging,
          input_good}; // R4 R5 R6 R12 R16
        `LCC_ADDR_MODE: reg_rdata_o <= {linear_regulator_mode,
          alternate_current_code, 4'h0};
        `LCC_ADDR_CONTROL: reg_rdata_o <= {4'h0, write_exact,
          current_source_select, healthy, charge_suspend}; // R14
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // current mapping
  lcc_current_map u_map (
    .primary_current_code_i(primary_current_code),
    .alternate_current_code_i(alternate_current_code),
    .use_alternate_i(level_s | current_source_select), // R15
    .current_level_i(level_s),
    .charge_ma_o(next_charge_ma)
  );

  // registered controls to charger
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      charge_start_o <= 1'b0;
      linear_regulator_mode_o <= 1'b0;
      charge_ma_o <= 10'h000;
      status_indicator_out_o <= 1'b0;
    end else begin
      charge_start_o <= input_good & ~float_s & ~charge_suspend &
        ~fault; // R13
      linear_regulator_mode_o <= linear_regulator_mode; // R8
      charge_ma_o <= next_charge_ma;
      status_indicator_out_o <= 1'b0;
    end
  end

  // open-drain indicator sinks while charging
  assign status_indicator_oe_o = charging; // R12

endmodule // lcc_regs
`default_nettype wire

// File: sim/lcc_host.sv
`timescale 1ns/1ns
`default_nettype none
module lcc_host (
  // clock and read data
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  // register write port
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic wr_o = 1'b0
);
  // one write pulse, write-exact bit kept at default
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d & 8'hf7;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // data settles a cycle after the address
  task rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= a;
    repeat (2) @(posedge clk_i);
    q = rdata_i;
  endtask
endmodule // lcc_host
`default_nettype wire

// File: sim/lcc_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module lcc_regs_monitor (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic thermal_fault_i,
  input wire logic current_level_float_i,
  input wire logic [1:0] charger_state_i,
  input wire logic charge_start_o,
  input wire logic linear_regulator_mode_o,
  input wire logic status_indicator_out_o,
  input wire logic status_indicator_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // write, then a cycle with no write there
  sequence s_wr(a);
    reg_wr_i && reg_addr_i == a ##1 !(reg_wr_i && reg_addr_i == a);
  endsequence
  a_mode_copy: assert property (s_wr(8'h0a) |=>
    linear_regulator_mode_o == $past(reg_wdata_i[7], 2)) else $error("mode");
  a_select_read: assert property (s_wr(8'h0b) ##0 reg_addr_i == 8'h0b
    |=> reg_rdata_o[2] == $past(reg_wdata_i[2], 2)) else $error("select");
  a_suspend_stop: assert property (reg_wr_i && reg_addr_i == 8'h0b &&
    reg_wdata_i[0] ##1 !reg_wr_i [*3] |-> !charge_start_o) else $error("susp");
  a_fault_stop: assert property (thermal_fault_i [*5] |->
    !charge_start_o) else $error("fault");
  a_float_stop: assert property (current_level_float_i [*5] |->
    !charge_start_o) else $error("float");
  a_idle_dark: assert property ((charger_state_i == 2'h0) [*5] |->
    !status_indicator_oe_o) else $error("idle");
  a_active_lit: assert property ((charger_state_i != 2'h0) [*5] |->
    status_indicator_oe_o) else $error("active");
  a_sink_only: assert property (status_indicator_out_o == 1'b0)
    else $error("drive");
endmodule // lcc_regs_monitor
bind lcc_regs lcc_regs_monitor u_mon (.ref_clk_i, .rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .thermal_fault_i,
  .current_level_float_i, .charger_state_i, .charge_start_o,
  .linear_regulator_mode_o, .status_indicator_out_o, .status_indicator_oe_o);
`default_nettype wire

// File: sim/lcc_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module lcc_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic abv = 1'b1, uv = 1'b1, th = 1'b0, bat = 1'b0, lvl = 1'b0, flt = 1'b0;
  logic [1:0] st = 2'h0;
  logic [7:0] addr, wd, rdata, q, r;
  logic wr, start, mode, sdrv, soe, g;
  logic [9:0] ma;
  logic [7:0] wm [4] = '{8'hf0, 8'hc0, 8'hf0, 8'h05};
  logic [7:0] fx [4] = '{8'h00, 8'h01, 8'h00, 8'h02};
  logic [7:0] cm [4] = '{8'hf0, 8'hd7, 8'hf0, 8'h0f};
  int n_errors = 0, compares = 0, seed = 32'h9392, d;
  // free-running clock
  always #5 clk = ~clk;
  lcc_host u_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wd),
    .wr_o(wr));
  lcc_regs #(.MIN_CYCLES(10)) u_dut (.ref_clk_i(clk), .rst_i(rst),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rdata_o(rdata),
    .input_above_battery_i(abv), .input_above_uvlo_i(uv),
    .thermal_fault_i(th), .battery_removed_i(bat),
    .current_level_pin_i(lvl), .current_level_float_i(flt),
    .charger_state_i(st), .charge_start_o(start),
    .linear_regulator_mode_o(mode), .charge_ma_o(ma),
    .status_indicator_out_o(sdrv), .status_indicator_oe_o(soe));
  // xorshift source
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // closing report
  task print_verdict();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      d = rnd();
      u_host.wr(8'(a + 8), d[7:0]);
      u_host.wr(8'h07, ~d[7:0]);
      u_host.rd(8'(a + 8), q);
      chk(q & cm[a], (d[7:0] & wm[a]) | fx[a]);
    end
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      u_host.wr(8'h0b, {7'h00, d[8]});
      {abv, uv, th, bat, flt, st} <= d[6:0];
      repeat (4) @(posedge clk);
      g = abv & uv & !th & !bat;
      u_host.rd(8'h09, q);
      u_host.rd(8'h0b, r);
      chk({start, soe, q & 8'h17, r[1]}, {g & !flt & !d[8], st != 0, 3'h0,
        bat, 1'b0, th, st != 0, abv & uv, g});
    end
    $display("status test done");
    {abv, uv, th, bat, flt, st} <= 7'h60;
    for (int c = 0; c < 16; c++) begin
      u_host.wr(8'h08, 8'(c << 4));
      repeat (2) @(posedge clk);
      chk(16'(ma), 16'(c == 0 ? 90 : 250 + 50 * c));
    end
    u_host.wr(8'h0a, 8'h00);
    lvl <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(ma), 16'd300);
    lvl <= 1'b0;
    u_host.wr(8'h0b, 8'h04);
    for (int c = 0; c < 8; c++) begin
      d = rnd() & 32'h80;
      u_host.wr(8'h0a, 8'(c << 4 | d));
      repeat (2) @(posedge clk);
      chk({mode, ma}, {d[7], 10'(300 + 100 * c)});
    end
    $display("current test done");
    rst <= 1'b1;
    {abv, uv, th, bat, flt, st} <= 7'h62;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (560) @(posedge clk);
    u_host.rd(8'h09, q);
    chk(16'(q[3]), 16'h0);
    repeat (60) @(posedge clk);
    u_host.rd(8'h09, q);
    chk({q[3], start}, 16'h2);
    $display("timer test done");
    print_verdict();
  end
endmodule // lcc_regs_tb
`default_nettype wire
